// >>> design/vpam_top.sv
// Overview of operation
// [R1] Relocation off: virtual address passes unchanged
// [R2] Pages 64-byte aligned, at most 8192 bytes
// [R3] Virtual bits 15:13 pick page register
// [R4] Bits 12:0 are offset in page
// [R5] Bits 12:6 are block number
// [R6] Bits 5:0 are byte in block
// [R7] Choose instruction or data register set
// [R8] Physical block is base plus block
// [R9] Physical address is block then byte
// [R10] 18 and 22-bit modes differ in width
// [R11] Relocation and DMA map enabled separately
// [R12] Top four ones go to peripheral bus
// [R13] Strip top four bits for bus address
// [R14] Lower range goes to main memory
// [R15] Top 8K of bus is device page
// [R16] Above installed memory is nonexistent
// [R17] DMA map relocates below device page only
// [R18] Memory populated contiguously from zero
// [R19] Status word bits 15:14 give mode
// [R20] Status three bits 2:0 enable data space
// [R21] DMA map: 5-bit select, add 22-bit base
// [R22] Unrelocated top 8K reaches bus top
// [R23] Base field width is a parameter
//
// Purpose: Processor and DMA address construction with APB registers
// Assumes: One cycle APB answer, zero wait states
// Notes:   Results are registered one cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "vpam_defines.svh"
module vpam_top #(
    parameter int BASE_W = 16
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Processor request
    input  wire logic        cpu_req,
    input  wire logic [15:0] virtual_address_word,
    input  wire logic        cpu_data_ref,
    input  wire logic [15:0] processor_status_word,
    // Processor result
    output logic             cpu_valid,
    output vpam_pkg::vpam_result_s cpu_result,
    // Peripheral DMA request
    input  wire logic        peripheral_dma_request,
    input  wire logic [17:0] dma_bus_addr,
    // DMA result
    output logic             dma_valid,
    output logic             dma_unmapped,
    output logic [21:0]      dma_physical_addr
);
    // =====================================================
    // Register storage
    // =====================================================
    logic              reloc_en;
    logic              dma_map_en;
    logic [2:0]        mmu_status_three;
    logic [21:0]       mem_top;
    logic [BASE_W-1:0] page_base_reg [0:2][0:1][0:7];
    logic [21:0]       dma_map_reg [0:31];
    logic [1:0]        cpu_mode;
    logic              use_d;
    logic [2:0]        page_select_field;
    logic [BASE_W-1:0] sel_base;
    logic [21:0]       xl_phys;
    logic [21:0]       dma_sum;
    logic              apb_wr;
    logic              apb_rd;
    logic [11:0]       pb_hi;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign pb_hi  = paddr & 12'hF00;

    // =====================================================
    // APB writes
    // =====================================================
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            reloc_en         <= 1'b0;
            dma_map_en       <= 1'b0;
            mmu_status_three <= 3'h0;
            mem_top          <= `VPAM_MEMTOP_RST;
        end
        else if (apb_wr)
        begin
            // [R11] Separate enables
            if (paddr == `VPAM_OFF_CTRL)
            begin
                reloc_en   <= pwdata[0];
                dma_map_en <= pwdata[1];
            end
            if (paddr == `VPAM_OFF_STAT3)
                mmu_status_three <= pwdata[2:0];
            if (paddr == `VPAM_OFF_MEMTOP)
                mem_top <= pwdata[21:0];
        end
    end

    // Page registers: mode(2b) space(1b) page(3b) word index
    always_ff @(posedge ref_clk)
    begin
        if (apb_wr && pb_hi == `VPAM_OFF_PBASE && paddr[7:6] != 2'h3)
            page_base_reg[paddr[7:6]][paddr[5]][paddr[4:2]] <= pwdata[BASE_W-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (apb_wr && pb_hi == `VPAM_OFF_DMAMAP && paddr[7] == 1'b0)
            dma_map_reg[paddr[6:2]] <= pwdata[21:0];
    end

    // =====================================================
    // APB reads
    // =====================================================
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (apb_rd)
            begin
                prdata <= 32'h0;
                if (paddr == `VPAM_OFF_CTRL)
                    prdata <= {30'h0, dma_map_en, reloc_en};
                else if (paddr == `VPAM_OFF_STAT3)
                    prdata <= {29'h0, mmu_status_three};
                else if (paddr == `VPAM_OFF_MEMTOP)
                    prdata <= {10'h0, mem_top};
                else if (paddr == `VPAM_OFF_STAT)
                    prdata <= {28'h0, cpu_result.dev_page, cpu_result.dest, cpu_valid};
                else if (paddr == `VPAM_OFF_LASTPA)
                    prdata <= {10'h0, cpu_result.physical_addr};
                else if (pb_hi == `VPAM_OFF_PBASE && paddr[7:6] != 2'h3)
                    prdata <= 32'(page_base_reg[paddr[7:6]][paddr[5]][paddr[4:2]]);
                else if (pb_hi == `VPAM_OFF_DMAMAP && paddr[7] == 1'b0)
                    prdata <= {10'h0, dma_map_reg[paddr[6:2]]};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // =====================================================
    // Processor translation
    // =====================================================
    // [R19] Mode from status word
    assign cpu_mode = processor_status_word[`VPAM_MODE_HI:`VPAM_MODE_LO];
    // [R20] Data space per mode
    assign use_d = cpu_data_ref && (cpu_mode != 2'h3) && mmu_status_three[cpu_mode];
    // [R3] Page select
    assign page_select_field = virtual_address_word[`VPAM_SEL_HI:`VPAM_SEL_LO];
    // [R7] Mode set chosen first, then space set; mode 2'h3 is illegal, folded onto mode 0
    assign sel_base = page_base_reg[(cpu_mode == 2'h3) ? 2'h0 : cpu_mode][use_d][page_select_field];

    // [R4] [R5] [R6] [R2] [R23] Field split inside
    vpam_xlate #(
        .BASE_W (BASE_W)
    ) u_xlate (
        .virtual_address_word (virtual_address_word),
        .page_base_field      (sel_base),
        .reloc_on             (reloc_en),
        .physical_addr        (xl_phys)
    );

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cpu_valid  <= 1'b0;
            cpu_result <= '0;
        end
        else
        begin
            cpu_valid <= cpu_req;
            if (cpu_req)
            begin
                cpu_result.physical_addr <= xl_phys;
                // [R13] Strip top bits
                cpu_result.bus_addr <= xl_phys[17:0];
                // [R15] Device page
                cpu_result.dev_page <= (xl_phys[21:18] == `VPAM_BUS_TOP)
                    && (xl_phys[17:13] == `VPAM_DEVPAGE_SEL);
                // [R12] [R14] [R16] Steering
                if (xl_phys[21:18] == `VPAM_BUS_TOP)
                    cpu_result.dest <= vpam_pkg::VPAM_DEST_BUS;
                else if (xl_phys > mem_top)
                    cpu_result.dest <= vpam_pkg::VPAM_DEST_ABSENT;
                else
                    cpu_result.dest <= vpam_pkg::VPAM_DEST_MEM;
            end
        end
    end

    // =====================================================
    // Peripheral DMA map
    // =====================================================
    // [R21] Select and add
    assign dma_sum = dma_map_reg[dma_bus_addr[`VPAM_DMA_SEL_HI:`VPAM_DMA_SEL_LO]]
        + {9'h0, dma_bus_addr[`VPAM_OFF_HI:0]};

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dma_valid         <= 1'b0;
            dma_unmapped      <= 1'b0;
            dma_physical_addr <= 22'h0;
        end
        else
        begin
            dma_valid <= peripheral_dma_request;
            if (peripheral_dma_request)
            begin
                // [R17] Device page untouched
                if (dma_bus_addr[`VPAM_DMA_SEL_HI:`VPAM_DMA_SEL_LO] == `VPAM_DEVPAGE_SEL)
                begin
                    dma_unmapped      <= 1'b1;
                    dma_physical_addr <= {`VPAM_BUS_TOP, dma_bus_addr};
                end
                // [R11] Map off passes through
                else if (!dma_map_en)
                begin
                    dma_unmapped      <= 1'b0;
                    dma_physical_addr <= {4'h0, dma_bus_addr};
                end
                else
                begin
                    dma_unmapped      <= 1'b0;
                    dma_physical_addr <= dma_sum;
                end
            end
        end
    end

    // =====================================================
    // Checks
    // =====================================================
    property p_direct;
        @(posedge ref_clk) disable iff (rst)
        (cpu_req && !reloc_en && virtual_address_word[15:13] != 3'h7)
        |=> cpu_result.physical_addr == {6'h00, $past(virtual_address_word)};
    endproperty
    a_direct: assert property (p_direct) else $error("direct pass wrong"); // [R1]

    property p_bus;
        @(posedge ref_clk) disable iff (rst)
        cpu_valid && cpu_result.physical_addr[21:18] == 4'hF |-> cpu_result.dest == vpam_pkg::VPAM_DEST_BUS;
    endproperty
    a_bus: assert property (p_bus) else $error("bus steering wrong"); // [R12]

    property p_strip;
        @(posedge ref_clk) disable iff (rst)
        cpu_valid |-> cpu_result.bus_addr == cpu_result.physical_addr[17:0];
    endproperty
    a_strip: assert property (p_strip) else $error("bus address wrong"); // [R13]

    property p_dmaoff;
        @(posedge ref_clk) disable iff (rst)
        peripheral_dma_request && dma_bus_addr[17:13] != 5'h1F && !dma_map_en
        |=> dma_physical_addr == {4'h0, $past(dma_bus_addr)} && dma_valid;
    endproperty
    a_dmaoff: assert property (p_dmaoff) else $error("dma pass wrong"); // [R11]

    property p_devpage;
        @(posedge ref_clk) disable iff (rst)
        peripheral_dma_request && dma_bus_addr[17:13] == 5'h1F |=> dma_unmapped;
    endproperty
    a_devpage: assert property (p_devpage) else $error("device page mapped"); // [R17]

    property p_iopage;
        @(posedge ref_clk) disable iff (rst)
        cpu_req && !reloc_en && virtual_address_word[15:13] == 3'h7
        |=> cpu_result.dest == vpam_pkg::VPAM_DEST_BUS && cpu_result.dev_page;
    endproperty
    a_iopage: assert property (p_iopage) else $error("top page not on bus"); // [R22]

    property p_absent;
        @(posedge ref_clk) disable iff (rst)
        cpu_valid && cpu_result.dest == vpam_pkg::VPAM_DEST_ABSENT |-> cpu_result.physical_addr > mem_top;
    endproperty
    a_absent: assert property (p_absent) else $error("absent memory steering wrong"); // [R16]

    property p_offset;
        @(posedge ref_clk) disable iff (rst)
        cpu_req && reloc_en |=> cpu_result.physical_addr[5:0] == $past(virtual_address_word[5:0]);
    endproperty
    a_offset: assert property (p_offset) else $error("byte offset changed"); // [R9]
endmodule
`default_nettype wire

// >>> design/vpam_defines.svh
// Purpose: Constants for the virtual to physical address map
// Assumes: 16-bit virtual, 22-bit physical, 18-bit peripheral bus
// Notes:   Included by bare name
`ifndef VPAM_DEFINES_SVH
`define VPAM_DEFINES_SVH
`define VPAM_VA_W        16
`define VPAM_PHYS_W      22
`define VPAM_BUS_W       18
`define VPAM_SEL_HI      15
`define VPAM_SEL_LO      13
`define VPAM_BLK_HI      12
`define VPAM_BLK_LO      6
`define VPAM_BYTE_HI     5
`define VPAM_OFF_HI      12
`define VPAM_MODE_HI     15
`define VPAM_MODE_LO     14
`define VPAM_DMA_SEL_HI  17
`define VPAM_DMA_SEL_LO  13
`define VPAM_BUS_TOP     4'hF
`define VPAM_DEVPAGE_SEL 5'h1F
`define VPAM_VA_IOPAGE   3'h7
// Register offsets (byte addresses)
`define VPAM_OFF_CTRL    12'h000
`define VPAM_OFF_STAT3   12'h004
`define VPAM_OFF_MEMTOP  12'h008
`define VPAM_OFF_STAT    12'h00C
`define VPAM_OFF_LASTPA  12'h010
`define VPAM_OFF_PBASE   12'h100
`define VPAM_OFF_DMAMAP  12'h200
`define VPAM_MEMTOP_RST  22'h000000
`endif

// >>> design/vpam_pkg.sv
// Purpose: Types for the virtual to physical address map
// Assumes: vpam_defines.svh
// Notes:   Types only
`default_nettype none
package vpam_pkg;
    typedef enum logic [1:0] {
        VPAM_DEST_MEM = 2'b00,
        VPAM_DEST_BUS = 2'b01,
        VPAM_DEST_ABSENT = 2'b10
    } vpam_dest_e;
    typedef struct packed {
        logic [21:0] physical_addr;
        logic [17:0] bus_addr;
        vpam_dest_e  dest;
        logic        dev_page;
    } vpam_result_s;
endpackage
`default_nettype wire

// >>> design/vpam_xlate.sv
// Purpose: Combinational relocation of one virtual address
// Assumes: Page base already selected by caller
// Notes:   Base field width is a parameter
`timescale 1ns/1ps
`default_nettype none
`include "vpam_defines.svh"
module vpam_xlate #(
    parameter int BASE_W = 16
) (
    // Address in
    input  wire logic [15:0]       virtual_address_word,
    input  wire logic [BASE_W-1:0] page_base_field,
    input  wire logic              reloc_on,
    // Address out
    output logic [21:0]            physical_addr
);
    logic [BASE_W-1:0] block_sum;
    // [R8] Block add
    assign block_sum = page_base_field
        + BASE_W'(virtual_address_word[`VPAM_BLK_HI:`VPAM_BLK_LO]);
    always_comb
    begin
        if (!reloc_on)
        begin
            // [R1] Direct pass
            physical_addr = {6'h00, virtual_address_word};
            // [R22] Top page to bus
            if (virtual_address_word[`VPAM_SEL_HI:`VPAM_SEL_LO] == `VPAM_VA_IOPAGE)
                physical_addr[21:16] = 6'h3F;
        end
        else
        begin
            // [R9] Concatenate offset
            physical_addr = 22'({block_sum, virtual_address_word[`VPAM_BYTE_HI:0]});
            // [R10] 18-bit mode: top 8K page moved to bus top
            if (BASE_W < 16 && physical_addr[17:13] == `VPAM_DEVPAGE_SEL)
                physical_addr[21:18] = `VPAM_BUS_TOP;
        end
    end
endmodule
`default_nettype wire

// >>> verification/vpam_cpu_model.sv
// Purpose: Processor core model issuing virtual addresses
// Assumes: Caller starts each request just after a rising edge
// Notes:   Released lines except the status word show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module vpam_cpu_model (
    // Clock
    input  wire logic   ref_clk,
    // Request out
    output logic        cpu_req,
    output logic [15:0] virtual_address_word,
    output logic        cpu_data_ref,
    output logic [15:0] processor_status_word
);
    initial
    begin
        cpu_req = 1'b0;
        virtual_address_word = 16'h0000;
        cpu_data_ref = 1'b0;
        processor_status_word = 16'h0000;
    end

    task automatic issue(input logic [15:0] va, input logic dref, input logic [1:0] mode);
        cpu_req <= 1'b1;
        virtual_address_word <= va;
        cpu_data_ref <= dref;
        processor_status_word <= {mode, 14'h0000};
        @(posedge ref_clk);
        // Inverted after release so a stale value cannot pass for a hold
        cpu_req <= 1'b0;
        virtual_address_word <= ~va;
        cpu_data_ref <= ~dref;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the address map
// Assumes: Zero wait APB answer, results one cycle after request
// Notes:   A second instance runs the 12-bit base width (18-bit relocation) on the same stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, cpu_req, cpu_data_ref, cpu_valid;
    logic peripheral_dma_request, dma_valid, dma_unmapped;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] virtual_address_word, processor_status_word;
    logic [17:0] dma_bus_addr;
    logic [21:0] dma_physical_addr;
    vpam_pkg::vpam_result_s cpu_result, cpu_result_n;
    int fails, check_count;
    logic [31:0] r;
    logic e, sp;
    logic [1:0] m;

    vpam_top #(.BASE_W(16)) i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu_req(cpu_req), .virtual_address_word(virtual_address_word),
        .cpu_data_ref(cpu_data_ref), .processor_status_word(processor_status_word),
        .cpu_valid(cpu_valid), .cpu_result(cpu_result), .peripheral_dma_request(peripheral_dma_request),
        .dma_bus_addr(dma_bus_addr), .dma_valid(dma_valid), .dma_unmapped(dma_unmapped),
        .dma_physical_addr(dma_physical_addr));

    vpam_cpu_model i_cpu (.ref_clk(ref_clk), .cpu_req(cpu_req), .virtual_address_word(virtual_address_word),
        .cpu_data_ref(cpu_data_ref), .processor_status_word(processor_status_word));

    // Narrow base field: 18-bit relocation fed by the same bus and requests
    vpam_top #(.BASE_W(12)) i_dut_narrow (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(), .pslverr(),
        .cpu_req(cpu_req), .virtual_address_word(virtual_address_word), .cpu_data_ref(cpu_data_ref),
        .processor_status_word(processor_status_word), .cpu_valid(), .cpu_result(cpu_result_n),
        .peripheral_dma_request(peripheral_dma_request), .dma_bus_addr(dma_bus_addr), .dma_valid(),
        .dma_unmapped(), .dma_physical_addr());

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ========================================
    // Checking and bus tasks
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 8)
        begin
            @(posedge ref_clk);
            n++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (n >= 8)
        begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic ee);
        apb(1'b0, a, 32'h00000000);
        chk("read data", ex, r);
        chk("read error", {31'h0, ee}, {31'h0, e});
    endtask

    task automatic wait_flag(input logic use_dma);
        int n;
        n = 0;
        #1;
        while ((use_dma ? dma_valid : cpu_valid) !== 1'b1 && n < 8)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 8)
        begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic cpu(input logic [15:0] va, input logic d, input logic [1:0] md, input logic [21:0] phys,
                       input logic [1:0] dst);
        i_cpu.issue(va, d, md);
        wait_flag(1'b0);
        chk("cpu physical", {10'h0, phys}, {10'h0, cpu_result.physical_addr});
        chk("cpu dest", {30'h0, dst}, {30'h0, cpu_result.dest});
        if (dst == vpam_pkg::VPAM_DEST_BUS)
        begin
            chk("cpu bus addr", {14'h0, phys[17:0]}, {14'h0, cpu_result.bus_addr});
            chk("cpu dev page", {31'h0, phys[17:13] == 5'h1F}, {31'h0, cpu_result.dev_page});
        end
        @(posedge ref_clk);
    endtask

    task automatic dma(input logic [17:0] ba, input logic [21:0] phys, input logic un);
        peripheral_dma_request <= 1'b1;
        dma_bus_addr <= ba;
        @(posedge ref_clk);
        peripheral_dma_request <= 1'b0;
        dma_bus_addr <= ~ba;
        wait_flag(1'b1);
        chk("dma physical", {10'h0, phys}, {10'h0, dma_physical_addr});
        chk("dma unmapped", {31'h0, un}, {31'h0, dma_unmapped});
        @(posedge ref_clk);
    endtask

    function automatic logic [21:0] rel(input logic [15:0] base, input logic [15:0] va);
        logic [15:0] b;
        b = base + {9'h000, va[12:6]};
        return {b, va[5:0]};
    endfunction

    function automatic logic [15:0] bse(input logic [1:0] md, input logic s);
        return 16'h1000 + {5'h00, md, s, 8'h00};
    endfunction

    // ========================================
    // Main sequence
    initial
    begin
        {rst, psel, penable, pwrite, peripheral_dma_request} = 5'h10;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        dma_bus_addr = 18'h00000;
        fails = 0;
        check_count = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(12'h000, 32'h0, 1'b0);
        rd(12'h004, 32'h0, 1'b0);
        rd(12'h008, 32'h0, 1'b0);
        rd(12'h0F0, 32'h0, 1'b1);
        // Memory filled from zero up to this top
        apb(1'b1, 12'h008, 32'h000FFFFF);
        cpu(16'h1234, 1'b0, 2'h0, 22'h001234, vpam_pkg::VPAM_DEST_MEM);
        cpu(16'hE010, 1'b0, 2'h0, 22'h3FE010, vpam_pkg::VPAM_DEST_BUS);
        for (int i = 0; i < 4; i++)
            apb(1'b1, 12'h100 + {4'h0, 1'b0, i[1], i[0], 5'h18}, {16'h0, bse({1'b0, i[1]}, i[0])});
        rd(12'h1D8, 32'h0, 1'b1);
        apb(1'b1, 12'h004, 32'h00000001);
        apb(1'b1, 12'h000, 32'h00000001);
        for (int i = 0; i < 4; i++)
        begin
            m = {1'b0, i[1]};
            sp = i[0] && (m == 2'h0);
            cpu(16'hDFE6, i[0], m, rel(bse(m, sp), 16'hDFE6), vpam_pkg::VPAM_DEST_MEM);
        end
        apb(1'b1, 12'h118, 32'h0000BB30);
        cpu(16'hDFE6, 1'b0, 2'h0, 22'h2EEBE6, vpam_pkg::VPAM_DEST_ABSENT);
        apb(1'b1, 12'h008, 32'h003BFFFF);
        cpu(16'hDFE6, 1'b0, 2'h0, 22'h2EEBE6, vpam_pkg::VPAM_DEST_MEM);
        apb(1'b1, 12'h118, 32'h0000FFC0);
        cpu(16'hC010, 1'b0, 2'h0, 22'h3FF010, vpam_pkg::VPAM_DEST_BUS);
        chk("narrow physical", 32'h003FF010, {10'h0, cpu_result_n.physical_addr});
        rd(12'h118, 32'h0000FFC0, 1'b0);
        cpu(16'hC010, 1'b1, 2'h3, 22'h3FF010, vpam_pkg::VPAM_DEST_BUS);
        rd(12'h010, 32'h003FF010, 1'b0);
        rd(12'h00C, 32'h0000000A, 1'b0);
        dma(18'h12345, 22'h012345, 1'b0);
        apb(1'b1, 12'h204, 32'h00100000);
        rd(12'h204, 32'h00100000, 1'b0);
        apb(1'b1, 12'h000, 32'h00000002);
        dma(18'h02010, 22'h100010, 1'b0);
        dma(18'h3E123, 22'h3FE123, 1'b1);
        cpu(16'h1234, 1'b0, 2'h0, 22'h001234, vpam_pkg::VPAM_DEST_MEM);
        wrap_up();
    end
endmodule
`default_nettype wire
